// ---- uaar_defines.svh ----
// Purpose: constants of the address recognition UART receiver
// Assumes: 25 MHz clock, 16x oversampled receive
// Notes: offsets are register indices on the plain register port
`ifndef UAAR_DEFINES_SVH
`define UAAR_DEFINES_SVH
`define UAAR_OFF_SLAVE_ADDR 8'hA9
`define UAAR_OFF_SLAVE_MASK 8'hB9
`define UAAR_OFF_CTRL 8'hC0
`define UAAR_OFF_STATUS 8'hC1
`define UAAR_OFF_BUF 8'hC2
`define UAAR_OFF_IRQ_STAT 8'hC4
`define UAAR_OFF_IRQ_EN 8'hC5
`define UAAR_OFF_IRQ_CLR 8'hC6
`define UAAR_RST_ADDR 8'h00
`define UAAR_RST_MASK 8'h00
`define UAAR_RST_DIV 16'h000C
`define UAAR_CTRL_MPE 0
`define UAAR_CTRL_REN 1
`define UAAR_CTRL_M0 2
`define UAAR_CTRL_M1 3
`define UAAR_ST_DONE 0
`define UAAR_ST_NINTH 1
`define UAAR_ST_FE 2
`define UAAR_EV_DONE 0
`define UAAR_EV_FE 1
`define UAAR_EV_DROP 2
`define UAAR_OVS_LAST 4'hF
`define UAAR_OVS_MID 4'h7
`define UAAR_DATA_BITS 4'h8
`endif

// ---- uaar_pkg.sv ----
// Purpose: shared types of the address recognition UART receiver
// Assumes: nothing beyond the defines header
// Notes: frame modes follow the usual four-mode serial port
package uaar_pkg;
  typedef enum logic [1:0]
  {
    UAAR_MODE_SYNC,
    UAAR_MODE_TEN,
    UAAR_MODE_NINE_FIX,
    UAAR_MODE_NINE_VAR
  } uaar_mode_e;

  typedef struct packed
  {
    logic valid;
    logic [7:0] data;
    logic ninth;
    logic stop_ok;
  } uaar_frame_s;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] mask;
  } uaar_match_cfg_s;
endpackage

// ---- uaar_match.sv ----
// Purpose: given and broadcast address comparison
// Assumes: pure combinational, same clock as caller
// Notes: zero mask means every byte matches
`timescale 1ns/1ps
`default_nettype none
module uaar_match
  import uaar_pkg::*;
(
  // Configuration and byte
  input wire uaar_match_cfg_s cfg,
  input wire logic [7:0] rx_byte,
  // Result
  output logic hit
);
  logic [7:0] bcast_care;
  logic given_hit;
  logic bcast_hit;

  always_comb
  begin
    given_hit = ((rx_byte ^ cfg.addr) & cfg.mask) == 8'h00;
    bcast_care = cfg.addr | cfg.mask;
    bcast_hit = ((rx_byte ^ bcast_care) & bcast_care) == 8'h00;
    hit = given_hit | bcast_hit;
  end
endmodule
`default_nettype wire

// ---- uaar_rx.sv ----
// Purpose: asynchronous frame receiver, 16x oversampled, 2 of 3 vote
// Assumes: rxd already synchronised by the caller
// Notes: emits one frame pulse per frame, stop bit reported separately
`timescale 1ns/1ps
`default_nettype none
`include "uaar_defines.svh"
module uaar_rx
  import uaar_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Control
  input wire logic enable,
  input wire logic nine_bit,
  input wire logic tick16,
  input wire logic rxd,
  // Frame out
  output uaar_frame_s frame
);
  typedef enum logic [1:0] {S_IDLE, S_START, S_BITS, S_STOP} uaar_rxst_e;
  typedef struct packed
  {
    uaar_rxst_e st;
    logic [3:0] ovs;
    logic [3:0] nbit;
    logic [8:0] shf;
    logic [2:0] smp;
    logic prev;
    uaar_frame_s fr;
  } uaar_rx_s;

  uaar_rx_s r_q;
  uaar_rx_s r_d;
  logic vote;

  always_comb
  begin
    r_d = r_q;
    r_d.fr.valid = 1'b0;
    vote = (r_q.smp[0] & r_q.smp[1]) | (r_q.smp[1] & r_q.smp[2]) |
      (r_q.smp[0] & r_q.smp[2]);
    if (tick16)
    begin
      r_d.prev = rxd;
      r_d.ovs = r_q.ovs + 4'h1;
      // Samples at states 7, 8 and 9 of the bit
      if (r_q.ovs >= `UAAR_OVS_MID && r_q.ovs <= `UAAR_OVS_MID + 4'h2)
        r_d.smp = {r_q.smp[1:0], rxd};
      case (r_q.st)
        S_IDLE:
        begin
          // Falling edge realigns the oversample counter
          if (enable && r_q.prev && !rxd)
          begin
            r_d.st = S_START;
            r_d.ovs = 4'h1;
          end
        end
        S_START:
        begin
          if (r_q.ovs == `UAAR_OVS_LAST)
          begin
            r_d.st = vote ? S_IDLE : S_BITS;
            r_d.nbit = 4'h0;
          end
        end
        S_BITS:
        begin
          if (r_q.ovs == `UAAR_OVS_LAST)
          begin
            r_d.shf = {vote, r_q.shf[8:1]};
            r_d.nbit = r_q.nbit + 4'h1;
            if (r_q.nbit == (nine_bit ? `UAAR_DATA_BITS : 4'h7))
              r_d.st = S_STOP;
          end
        end
        S_STOP:
        begin
          // Frame ends in the middle of the stop bit
          if (r_q.ovs == `UAAR_OVS_MID + 4'h3)
          begin
            r_d.st = S_IDLE;
            r_d.fr.valid = 1'b1;
            r_d.fr.stop_ok = vote;
            r_d.fr.data = nine_bit ? r_q.shf[7:0] : r_q.shf[8:1];
            r_d.fr.ninth = nine_bit ? r_q.shf[8] : vote;
          end
        end
        default:
          r_d.st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_q <= '0;
      r_q.prev <= 1'b1;
    end
    else if (ce)
      r_q <= r_d;
  end

  assign frame = r_q.fr;
endmodule
`default_nettype wire

// ---- uaar_top.sv ----
// Purpose: UART receiver with automatic multiprocessor address recognition
// Assumes: single 25 MHz clock, plain register port, rxd from a pin
// Notes: baud divisor sets the 16x sample tick
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "uaar_defines.svh"
// What this block does
// - Ninth bit high marks address frames
// - Multiproc mode: done only on address match
// - Ten-bit mode uses stop bit as ninth
// - Multiproc off: every frame sets done, except in sync mode
// - Given address compares only masked bits
// - Broadcast address is address OR mask
// - Hardware compares every address byte
// - Address at A9h, mask at B9h
// - Both registers reset to zero
// - Load only if done clear and allowed
// - Ninth bit, or stop bit in ten-bit mode, to ninth; data to buffer
module uaar_top
  import uaar_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial line
  input wire logic rxd,
  // Status outputs
  output logic rx_done_flag,
  output logic irq
);
  typedef struct packed
  {
    logic [1:0] rxd_sync;
    uaar_match_cfg_s cfg;
    logic multiproc_enable;
    logic rx_en;
    uaar_mode_e mode;
    logic [15:0] div;
    logic [15:0] div_cnt;
    logic tick16;
    logic rx_done_flag;
    logic rx_ninth_bit;
    logic frame_err;
    logic [7:0] serial_buffer;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [7:0] rdata;
    logic irq;
  } uaar_top_s;

  uaar_top_s s_q;
  uaar_top_s s_d;
  uaar_frame_s frame;
  logic hit;
  logic nine_bit;
  logic accept;
  logic filt_ok;
  logic [2:0] ev;

  assign nine_bit = (s_q.mode == UAAR_MODE_NINE_FIX) ||
    (s_q.mode == UAAR_MODE_NINE_VAR);

  uaar_rx u_rx
  (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .enable(s_q.rx_en),
    .nine_bit(nine_bit),
    .tick16(s_q.tick16),
    .rxd(s_q.rxd_sync[1]),
    .frame(frame)
  );

  uaar_match u_match
  (
    .cfg(s_q.cfg),
    .rx_byte(frame.data),
    .hit(hit)
  );

  always_comb
  begin
    s_d = s_q;
    // Two flops before the receiver sees the pin
    s_d.rxd_sync = {s_q.rxd_sync[0], rxd};
    s_d.tick16 = 1'b0;
    if (s_q.div_cnt == 16'h0000)
    begin
      s_d.div_cnt = s_q.div;
      s_d.tick16 = 1'b1;
    end
    else
      s_d.div_cnt = s_q.div_cnt - 16'h0001;

    filt_ok = !s_q.multiproc_enable || (frame.ninth && hit);
    accept = frame.valid && !s_q.rx_done_flag && filt_ok &&
      s_q.mode != UAAR_MODE_SYNC;
    ev = 3'h0;
    if (accept)
    begin
      s_d.serial_buffer = frame.data;
      s_d.rx_ninth_bit = frame.ninth;
      s_d.rx_done_flag = 1'b1;
      ev[`UAAR_EV_DONE] = 1'b1;
    end
    // Drop event only when a wanted frame meets a done flag still set
    else if (frame.valid && filt_ok && s_q.rx_done_flag)
      ev[`UAAR_EV_DROP] = 1'b1;
    if (frame.valid && !frame.stop_ok)
    begin
      s_d.frame_err = 1'b1;
      ev[`UAAR_EV_FE] = 1'b1;
    end

    s_d.rdata = 8'h00;
    if (reg_wr)
    begin
      case (reg_addr)
        `UAAR_OFF_SLAVE_ADDR: s_d.cfg.addr = reg_wdata;
        `UAAR_OFF_SLAVE_MASK: s_d.cfg.mask = reg_wdata;
        `UAAR_OFF_CTRL:
        begin
          s_d.multiproc_enable = reg_wdata[`UAAR_CTRL_MPE];
          s_d.rx_en = reg_wdata[`UAAR_CTRL_REN];
          s_d.mode = uaar_mode_e'(reg_wdata[`UAAR_CTRL_M1:`UAAR_CTRL_M0]);
        end
        `UAAR_OFF_STATUS:
        begin
          // Write one to clear; a same-cycle event wins
          if (reg_wdata[`UAAR_ST_DONE] && !accept)
            s_d.rx_done_flag = 1'b0;
          if (reg_wdata[`UAAR_ST_FE] && !ev[`UAAR_EV_FE])
            s_d.frame_err = 1'b0;
        end
        `UAAR_OFF_BUF: s_d.div[7:0] = reg_wdata;
        `UAAR_OFF_BUF + 8'h01: s_d.div[15:8] = reg_wdata;
        `UAAR_OFF_IRQ_EN: s_d.irq_en = reg_wdata[2:0];
        `UAAR_OFF_IRQ_CLR: s_d.irq_stat = s_q.irq_stat & ~reg_wdata[2:0];
        default: ;
      endcase
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    if (reg_rd)
    begin
      case (reg_addr)
        `UAAR_OFF_SLAVE_ADDR: s_d.rdata = s_q.cfg.addr;
        `UAAR_OFF_SLAVE_MASK: s_d.rdata = s_q.cfg.mask;
        `UAAR_OFF_CTRL:
          s_d.rdata = {4'h0, s_q.mode, s_q.rx_en, s_q.multiproc_enable};
        `UAAR_OFF_STATUS:
          s_d.rdata = {5'h00, s_q.frame_err, s_q.rx_ninth_bit,
            s_q.rx_done_flag};
        `UAAR_OFF_BUF: s_d.rdata = s_q.serial_buffer;
        `UAAR_OFF_BUF + 8'h01: s_d.rdata = s_q.div[15:8];
        `UAAR_OFF_IRQ_STAT: s_d.rdata = {5'h00, s_q.irq_stat};
        `UAAR_OFF_IRQ_EN: s_d.rdata = {5'h00, s_q.irq_en};
        default: s_d.rdata = 8'h00;
      endcase
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_en);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.rxd_sync <= 2'b11;
      s_q.cfg.addr <= `UAAR_RST_ADDR;
      s_q.cfg.mask <= `UAAR_RST_MASK;
      s_q.div <= `UAAR_RST_DIV;
    end
    else if (ce)
      s_q <= s_d;
  end

  assign reg_rdata = s_q.rdata;
  assign rx_done_flag = s_q.rx_done_flag;
  assign irq = s_q.irq;
endmodule
`default_nettype wire

// ---- uaar_line_model.sv ----
// Purpose: far-side master driving the serial line
// Assumes: 16 sample ticks per bit at the reset divisor
// Notes: line idles high between frames, as the model drives it high
`timescale 1ns/1ps
`default_nettype none
module uaar_line_model
#(
  parameter int BIT = 208
)
(
  // Clock
  input wire logic clk,
  // Serial line
  output logic rxd
);
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] d, input logic b9, m9, st);
    logic [10:0] f;
    int n;
    f = m9 ? {st, b9, d, 1'b0} : {1'b1, st, d, 1'b0};
    n = m9 ? 11 : 10;
    for (int i = 0; i < n; i++)
      repeat (BIT) @(posedge clk) rxd <= f[i];
    @(posedge clk) rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- uaar_assertions.sv ----
// Purpose: port checks of the address recognition receiver
// Assumes: ce held high by the bench
// Notes: shadows track what software wrote
`timescale 1ns/1ps
`default_nettype none
module uaar_assertions
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Serial and status
  input wire logic rxd,
  input wire logic rx_done_flag,
  input wire logic irq
);
  typedef struct packed
  {
    logic [7:0] a;
    logic [7:0] m;
    logic [7:0] c;
    logic [7:0] e;
  } uaar_shadow_s;
  uaar_shadow_s sh_q, sh_d;
  logic clr;
  assign clr = reg_wr && reg_addr == 8'hC1 && reg_wdata[0];
  always_comb
  begin
    sh_d = sh_q;
    if (reg_wr && ce && reg_addr == 8'hA9) sh_d.a = reg_wdata;
    if (reg_wr && ce && reg_addr == 8'hB9) sh_d.m = reg_wdata;
    if (reg_wr && ce && reg_addr == 8'hC0) sh_d.c = reg_wdata;
    if (reg_wr && ce && reg_addr == 8'hC5) sh_d.e = reg_wdata;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) sh_q <= '0;
    else sh_q <= sh_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  a_addr_read: assert property (reg_rd && reg_addr == 8'hA9
    |=> reg_rdata == sh_q.a) else $error("address register mismatch");
  a_mask_read: assert property (reg_rd && reg_addr == 8'hB9
    |=> reg_rdata == sh_q.m) else $error("mask register mismatch");
  a_done_hold: assert property (rx_done_flag && !clr |=> rx_done_flag)
    else $error("done flag dropped");
  a_done_clear: assert property (clr |=> ##[0:2] !rx_done_flag)
    else $error("done flag not cleared");
  a_done_mode: assert property ($rose(rx_done_flag)
    |-> sh_q.c[1] && sh_q.c[3:2] != 2'b00) else $error("done while off");
  // Stop bit sits ten clocks back when done rises mid stop
  a_ten_stop: assert property ($rose(rx_done_flag) && sh_q.c[0]
    && sh_q.c[3:2] == 2'b01 |-> $past(rxd, 10)) else $error("stop low");
  a_mp_ninth: assert property ($rose(rx_done_flag) && sh_q.c[0]
    && sh_q.c[3] |-> $past(rxd, 250)) else $error("ninth low accepted");
  a_irq_done: assert property ($rose(rx_done_flag) && sh_q.e[0]
    |-> ##[0:3] irq) else $error("interrupt missing");
  c_done: cover property ($rose(rx_done_flag));
  c_irq: cover property ($rose(irq));
  c_mp: cover property ($rose(rx_done_flag) && sh_q.c[0]);
endmodule
bind uaar_top uaar_assertions chk (.clk, .rst_b, .ce, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rxd, .rx_done_flag, .irq);
`default_nettype wire

// ---- uaar_bench.sv ----
// Purpose: self-checking bench of the address recognition receiver
// Assumes: reset divisor, 208 clocks per bit
// Notes: ce tied high; clock gating is not exercised
`timescale 1ns/1ps
`default_nettype none
module uaar_bench;
  logic clk, rst_b, reg_wr, reg_rd, rxd, rx_done_flag, irq, ien;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int miscompares, num_checks, cycles;
  uaar_top uut (.clk, .rst_b, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .rxd, .rx_done_flag, .irq);
  uaar_line_model far (.clk, .rxd);
  task automatic results;
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rc(input string n, input logic [7:0] a, e);
    logic [7:0] v;
    rd(a, v);
    check(n, v, e);
  endtask
  task automatic frame(input logic [7:0] d, input logic b9, m9, st, hit);
    logic [7:0] v;
    far.send(d, b9, m9, st);
    rd(8'hC1, v);
    check("done", {7'h0, v[0]}, {7'h0, hit});
    check("done pin", {7'h0, rx_done_flag}, {7'h0, hit});
    check("irq", {7'h0, irq}, {7'h0, hit & ien});
    if (hit)
    begin
      check("ninth", {7'h0, v[1]}, {7'h0, m9 ? b9 : st});
      rc("buffer", 8'hC2, d);
      wr(8'hC1, 8'h05);
      wr(8'hC6, 8'h07);
    end
  endtask
  task automatic t_regs;
    rc("addr rst", 8'hA9, 8'h00);
    rc("mask rst", 8'hB9, 8'h00);
    rc("unmapped", 8'h10, 8'h00);
    rc("div hi", 8'hC3, 8'h00);
    wr(8'hA9, 8'hA4);
    wr(8'hB9, 8'hFA);
    rc("addr", 8'hA9, 8'hA4);
    rc("mask", 8'hB9, 8'hFA);
  endtask
  task automatic t_plain;
    wr(8'hC5, 8'h01);
    ien = 1'b1;
    wr(8'hC0, 8'h06);
    frame(8'h3C, 1'b0, 1'b0, 1'b1, 1'b1);
    ien = 1'b0;
    wr(8'hC5, 8'h00);
    frame(8'hC3, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(8'hC0, 8'h02);
    frame(8'h5A, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(8'hC5, 8'h01);
    ien = 1'b1;
  endtask
  // Given 1010 0x0x, broadcast 1111 111x
  task automatic t_mp;
    wr(8'hC0, 8'h0B);
    frame(8'hA0, 1'b1, 1'b1, 1'b1, 1'b1);
    frame(8'hA2, 1'b1, 1'b1, 1'b1, 1'b0);
    frame(8'hA0, 1'b0, 1'b1, 1'b1, 1'b0);
    frame(8'hFF, 1'b1, 1'b1, 1'b1, 1'b1);
    frame(8'h7E, 1'b1, 1'b1, 1'b1, 1'b0);
    wr(8'hC0, 8'h0F);
    frame(8'hA5, 1'b1, 1'b1, 1'b1, 1'b1);
    wr(8'hC0, 8'h0E);
    frame(8'h12, 1'b0, 1'b1, 1'b1, 1'b1);
  endtask
  task automatic t_ten_drop;
    wr(8'hC0, 8'h07);
    frame(8'hA0, 1'b0, 1'b0, 1'b0, 1'b0);
    rc("stat fe", 8'hC1, 8'h04);
    rc("irq fe", 8'hC4, 8'h02);
    frame(8'hA0, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(8'hC0, 8'h06);
    far.send(8'h11, 1'b0, 1'b0, 1'b1);
    far.send(8'h22, 1'b0, 1'b0, 1'b1);
    rc("kept", 8'hC2, 8'h11);
    rc("irq drop", 8'hC4, 8'h05);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Frames cost about 2100 clocks each in ten-bit mode and about 2300 in nine-bit mode
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      miscompares++;
      results();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ien = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_plain();
    t_mp();
    t_ten_drop();
    results();
  end
endmodule
`default_nettype wire
